//--- rtl/sus_unlock_seek.v
`timescale 1ns/10ps
`include "sus_map.vh"
module sus_unlock_seek (
    // clock and reset
    input wire MCLK,
    input wire RST_N,
    // session reset without preservation (comreset)
    input wire SESS_RST,
    // command strobe and taskfile
    input wire CMD_VALID,
    input wire [7:0] CMD_CODE,
    input wire [7:0] LBA_LOW_IN,
    input wire [7:0] LBA_MID_IN,
    input wire [7:0] LBA_HIGH_IN,
    input wire [7:0] DEVICE_IN,
    // pio data-out words from host
    input wire DATA_VALID,
    input wire [15:0] DATA_WORD,
    // security configuration
    input wire SEC_ENABLED,
    input wire SEC_LEVEL_MAX,
    input wire FROZEN,
    input wire [255:0] MASTER_PW,
    input wire [255:0] USER_PW,
    // seek mechanics
    input wire SEEK_DONE,
    input wire SEEK_NOT_FOUND,
    input wire [27:0] SEEK_CUR_LBA,
    // outputs
    output wire DATA_READY,
    output reg SEEK_REQ,
    output reg [27:0] SEEK_TARGET,
    output reg SEEK_LBA_MODE,
    output reg [7:0] STATUS,
    output reg [7:0] ERROR,
    output reg [7:0] LBA_LOW_OUT,
    output reg [7:0] LBA_MID_OUT,
    output reg [7:0] LBA_HIGH_OUT,
    output reg [3:0] HEAD_OUT,
    output reg CMD_DONE,
    output wire LOCKED,
    output wire [2:0] TRIES_LEFT
);

    // states
    localparam ST_IDLE = 2'h0;
    localparam ST_DATA = 2'h1;
    localparam ST_SEEK = 2'h2;

    // seek decode, used for command taking
    function is_seek;
        input [7:0] code;
        begin
            is_seek = (code[7:4] == `SUS_SEEK_NIB);
        end
    endfunction

    reg [1:0] state_q, state_d;
    reg unlocked_q; // set only by a good compare
    reg [2:0] tries_q; // unlock attempts remaining
    reg sel_master_q; // captured identifier bit
    reg [7:0] word_q; // word index inside the sector
    reg [255:0] pw_q; // collected password
    reg lba_q; // lba mode of current seek

    assign LOCKED = SEC_ENABLED && !unlocked_q;
    assign TRIES_LEFT = tries_q;
    assign DATA_READY = (state_q == ST_DATA); // handshake, combinational

    // sector being completed this cycle including last word
    wire last_word = DATA_VALID && (word_q == `SUS_WORDS);
    wire master_ok = !SEC_LEVEL_MAX && (pw_q == MASTER_PW);
    wire user_ok = (pw_q == USER_PW);
    wire pw_match = sel_master_q ? master_ok : user_ok;
    wire [27:0] chs_or_lba = {DEVICE_IN[3:0], LBA_HIGH_IN, LBA_MID_IN, LBA_LOW_IN};

    // next state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (CMD_VALID && CMD_CODE == `SUS_CMD_UNLOCK && !FROZEN && tries_q != `SUS_TRIES_ZERO) begin
                    state_d = ST_DATA;
                end else if (CMD_VALID && is_seek(CMD_CODE)) begin
                    state_d = ST_SEEK;
                end
            end
            ST_DATA: begin
                if (last_word) begin
                    state_d = ST_IDLE;
                end
            end
            ST_SEEK: begin
                if (SEEK_DONE || SEEK_NOT_FOUND) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // main sequencer; only power-on reset reloads the attempt counter
    // a session reset clears the unlock but never the attempt counter,
    // so a host cannot buy fresh tries by toggling the link
    // when a session reset meets a good compare in one cycle the
    // later assignment below wins, so the unlock stands
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
            unlocked_q <= 1'b0;
            tries_q <= `SUS_TRIES_INIT;
            sel_master_q <= 1'b0;
            word_q <= 8'h00;
            pw_q <= 256'h0;
            lba_q <= 1'b0;
            SEEK_REQ <= 1'b0;
            SEEK_TARGET <= 28'h0;
            SEEK_LBA_MODE <= 1'b0;
            STATUS <= `SUS_STAT_IDLE;
            ERROR <= 8'h00;
            LBA_LOW_OUT <= 8'h00;
            LBA_MID_OUT <= 8'h00;
            LBA_HIGH_OUT <= 8'h00;
            HEAD_OUT <= 4'h0;
            CMD_DONE <= 1'b0;
        end else begin
            state_q <= state_d;
            CMD_DONE <= 1'b0;
            SEEK_REQ <= 1'b0;
            if (SESS_RST) begin
                unlocked_q <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    if (CMD_VALID && CMD_CODE == `SUS_CMD_UNLOCK) begin
                        ERROR <= 8'h00;
                        if (FROZEN || tries_q == `SUS_TRIES_ZERO) begin
                            // abort before sector: not a mismatch
                            ERROR[`SUS_ERR_ABORT] <= 1'b1;
                            STATUS <= `SUS_STAT_ABORT;
                            CMD_DONE <= 1'b1;
                        end else begin
                            word_q <= 8'h00;
                            STATUS <= `SUS_STAT_XFER; // ready plus drq
                        end
                    end else if (CMD_VALID && is_seek(CMD_CODE)) begin
                        // no format check: seek is purely positional
                        lba_q <= DEVICE_IN[`SUS_DEV_LBA_BIT];
                        SEEK_LBA_MODE <= DEVICE_IN[`SUS_DEV_LBA_BIT];
                        SEEK_TARGET <= chs_or_lba;
                        SEEK_REQ <= 1'b1;
                        ERROR <= 8'h00;
                        STATUS <= `SUS_STAT_BUSY; // busy
                    end
                end
                ST_DATA: begin
                    if (DATA_VALID) begin
                        word_q <= word_q + 8'h01;
                        if (word_q == 8'h00) begin
                            sel_master_q <= DATA_WORD[`SUS_SEL_BIT];
                        end else if (word_q >= `SUS_PW_FIRST && word_q <= `SUS_PW_LAST) begin
                            pw_q <= {DATA_WORD, pw_q[255:16]};
                        end
                    end
                    if (last_word) begin
                        CMD_DONE <= 1'b1;
                        if (pw_match) begin
                            unlocked_q <= 1'b1; // tries kept
                            STATUS <= `SUS_STAT_IDLE;
                        end else begin
                            // only a mismatch aborts after the sector
                            ERROR[`SUS_ERR_ABORT] <= 1'b1;
                            STATUS <= `SUS_STAT_ABORT;
                            tries_q <= tries_q - 3'h1;
                        end
                    end
                end
                ST_SEEK: begin
                    if (SEEK_NOT_FOUND) begin
                        // target missing: abort with not-found flag
                        ERROR[`SUS_ERR_NOTFOUND] <= 1'b1;
                        STATUS <= `SUS_STAT_ABORT;
                        CMD_DONE <= 1'b1;
                    end else if (SEEK_DONE) begin
                        STATUS <= `SUS_STAT_SEEKOK; // ready plus seek complete
                        CMD_DONE <= 1'b1;
                        if (lba_q) begin
                            LBA_LOW_OUT <= SEEK_CUR_LBA[7:0];
                            LBA_MID_OUT <= SEEK_CUR_LBA[15:8];
                            LBA_HIGH_OUT <= SEEK_CUR_LBA[23:16];
                            HEAD_OUT <= SEEK_CUR_LBA[27:24];
                        end
                    end
                end
                default: begin
                    STATUS <= `SUS_STAT_IDLE;
                end
            endcase
        end
    end

endmodule // sus_unlock_seek

//--- rtl/sus_map.vh
`ifndef SUS_MAP_VH
`define SUS_MAP_VH
// command codes
`define SUS_CMD_UNLOCK 8'hF2
`define SUS_SEEK_NIB 4'h7
// sector layout, in 16-bit words
`define SUS_WORDS 8'hFF
`define SUS_PW_FIRST 8'h01
`define SUS_PW_LAST 8'h10
// control word field
`define SUS_SEL_BIT 0
// attempt counter
`define SUS_TRIES_INIT 3'h5
`define SUS_TRIES_ZERO 3'h0
// device register field positions
`define SUS_DEV_LBA_BIT 6
// error register bit positions
`define SUS_ERR_ABORT 2
`define SUS_ERR_NOTFOUND 4
// status register bit positions
`define SUS_ST_ERR 0
`define SUS_ST_DRQ 3
`define SUS_ST_SEEKDONE 4
`define SUS_ST_READY 6
`define SUS_ST_BUSY 7
// status register codes returned to the host
`define SUS_STAT_IDLE 8'h40
`define SUS_STAT_ABORT 8'h41
`define SUS_STAT_XFER 8'h48
`define SUS_STAT_BUSY 8'h80
`define SUS_STAT_SEEKOK 8'h50
`endif

//--- verif/sus_mech_model.sv
`timescale 1ns/10ps
// seek mechanics: arrives at the target a chosen number of cycles after each request
module sus_mech_model (
    // request from the block
    input wire mclk,
    input wire rst_n,
    input wire req,
    input wire [27:0] target,
    input wire [3:0] delay,
    // arrival back to the block
    output reg done,
    output reg [27:0] cur_lba
);
    reg [4:0] cnt_q; // cycles to arrival, zero when idle
    // count down, then pulse done and move the head
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 5'h00;
            done <= 1'b0;
            cur_lba <= 28'h0000000;
        end else begin
            done <= cnt_q == 5'h01;
            cnt_q <= req ? 5'h01 + delay : cnt_q - (cnt_q != 5'h00);
            if (cnt_q == 5'h01) cur_lba <= target;
        end
    end
endmodule // sus_mech_model

//--- verif/sus_unlock_seek_sva.sv
`timescale 1ns/10ps
// timing checks on the unlock and seek ports
module sus_unlock_seek_sva (
    // host side inputs
    input wire MCLK, input wire RST_N, input wire SESS_RST, input wire CMD_VALID, input wire [7:0] CMD_CODE,
    input wire [7:0] LBA_LOW_IN, input wire [7:0] LBA_MID_IN, input wire [7:0] LBA_HIGH_IN,
    input wire [7:0] DEVICE_IN, input wire SEC_ENABLED, input wire FROZEN, input wire SEEK_DONE,
    // watched outputs
    input wire DATA_READY, input wire SEEK_REQ, input wire [27:0] SEEK_TARGET, input wire SEEK_LBA_MODE,
    input wire [7:0] STATUS, input wire [7:0] ERROR, input wire CMD_DONE, input wire LOCKED,
    input wire [2:0] TRIES_LEFT
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    wire idle = !STATUS[7] && !DATA_READY; // neither busy nor collecting
    wire take_unlock = CMD_VALID && idle && CMD_CODE == 8'hF2;
    wire [27:0] req_addr = {DEVICE_IN[3:0], LBA_HIGH_IN, LBA_MID_IN, LBA_LOW_IN};
    unlock_starts_a: assert property (take_unlock && !FROZEN && TRIES_LEFT != 3'h0
        |=> DATA_READY && STATUS[3]) else $error("unlock did not ask for the sector");
    unlock_refused_a: assert property (take_unlock && (FROZEN || TRIES_LEFT == 3'h0)
        |=> CMD_DONE && ERROR[2] && !DATA_READY) else $error("refused unlock not aborted at once");
    seek_starts_a: assert property (CMD_VALID && idle && CMD_CODE[7:4] == 4'h7 |=> SEEK_REQ
        && SEEK_TARGET == $past(req_addr) && SEEK_LBA_MODE == $past(DEVICE_IN[6])) else $error("bad seek start");
    seek_finish_a: assert property (SEEK_DONE |=> CMD_DONE && STATUS == 8'h50)
        else $error("seek completion not reported");
    mismatch_dec_a: assert property (CMD_DONE && ERROR[2] && $past(DATA_READY)
        |-> TRIES_LEFT == $past(TRIES_LEFT) - 3'h1) else $error("mismatch did not decrement");
    success_keep_a: assert property (CMD_DONE && !ERROR[2] && $past(DATA_READY)
        |-> TRIES_LEFT == $past(TRIES_LEFT) && !LOCKED) else $error("unlock success wrong");
    tries_no_rise_a: assert property (RST_N && $past(RST_N) |-> TRIES_LEFT <= $past(TRIES_LEFT))
        else $error("tries rose");
    session_relock_a: assert property (SESS_RST && SEC_ENABLED |=> LOCKED) else $error("no relock");
endmodule // sus_unlock_seek_sva
bind sus_unlock_seek sus_unlock_seek_sva i_sus_unlock_seek_sva (.*);

//--- verif/test_sus_unlock_seek.sv
`timescale 1ns/10ps
// host side: issues unlock and seek commands and checks the answers
module test_sus_unlock_seek;
    reg MCLK = 0, RST_N = 0, SESS_RST = 0, CMD_VALID = 0, DATA_VALID = 0, SEC_LEVEL_MAX = 0, FROZEN = 0;
    reg SEC_ENABLED = 1;
    reg [7:0] CMD_CODE = 0, LBA_LOW_IN = 0, LBA_MID_IN = 0, LBA_HIGH_IN = 0, DEVICE_IN = 0;
    reg [15:0] DATA_WORD = 0;
    reg [255:0] MASTER_PW, USER_PW;
    reg [3:0] delay = 0; // partner latency
    wire SEEK_DONE, DATA_READY, SEEK_REQ, SEEK_LBA_MODE, CMD_DONE, LOCKED;
    wire [27:0] SEEK_CUR_LBA, SEEK_TARGET;
    wire [7:0] STATUS, ERROR, LBA_LOW_OUT, LBA_MID_OUT, LBA_HIGH_OUT;
    wire [3:0] HEAD_OUT;
    wire [2:0] TRIES_LEFT;
    int err_count = 0, checked = 0, i, k, n;
    always #5 MCLK = ~MCLK;
    sus_unlock_seek i_sus_unlock_seek (.SEEK_NOT_FOUND(1'b0), .*);
    sus_mech_model i_sus_mech_model (.mclk(MCLK), .rst_n(RST_N), .req(SEEK_REQ), .target(SEEK_TARGET),
        .delay(delay), .done(SEEK_DONE), .cur_lba(SEEK_CUR_LBA));
    task chk(input [31:0] got, input [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // bounded wait for the one-cycle completion pulse
    task wait_done;
        n = 0;
        #1;
        while (CMD_DONE !== 1'b1 && n < 40) begin
            @(posedge MCLK);
            #1;
            n++;
        end
        if (CMD_DONE !== 1'b1) begin
            err_count++;
            report_and_stop;
        end
    endtask
    task cmd(input [7:0] c, input [27:0] a, input lba);
        @(posedge MCLK);
        CMD_VALID <= 1;
        CMD_CODE <= c;
        {DEVICE_IN, LBA_HIGH_IN, LBA_MID_IN, LBA_LOW_IN} <= {1'b1, lba, 2'b10, a};
        @(posedge MCLK);
        CMD_VALID <= 0;
    endtask
    // one full sector: control word, password, random reserved words
    task unlock(input sel, input [255:0] pw, input ab, input [2:0] tr);
        cmd(8'hF2, $urandom, 0);
        #1 chk(DATA_READY, 1);
        for (i = 0; i < 256; i++) begin
            @(posedge MCLK);
            DATA_VALID <= 1;
            DATA_WORD <= i == 0 ? 16'({$urandom, sel}) : (i < 17 ? pw[16 * i - 16 +: 16] : $urandom);
        end
        @(posedge MCLK);
        DATA_VALID <= 0;
        wait_done;
        chk({ERROR[2], TRIES_LEFT}, {ab, tr});
    endtask
    // a refusal completes one cycle after the command, before any data
    task refused;
        cmd(8'hF2, 0, 0);
        wait_done;
        chk({DATA_READY, ERROR[2], n[3:0]}, 6'h10);
    endtask
    task seek(input [3:0] lo, input lba);
        reg [27:0] a;
        a = $urandom;
        delay <= $urandom;
        cmd({4'h7, lo}, a, lba);
        #1 chk(SEEK_TARGET, a);
        wait_done;
        if (lba) chk({HEAD_OUT, LBA_HIGH_OUT, LBA_MID_OUT, LBA_LOW_OUT}, a);
    endtask
    initial begin
        n = $urandom(25884);
        for (k = 0; k < 8; k++) {MASTER_PW[32 * k +: 32], USER_PW[32 * k +: 32]} = {$urandom, $urandom};
        repeat (5) @(posedge MCLK);
        RST_N <= 1;
        unlock(0, USER_PW ^ {1'b1, 255'h0}, 1, 3'h4);
        unlock(1, MASTER_PW, 0, 3'h4);
        chk(LOCKED, 0);
        @(posedge MCLK) SESS_RST <= 1;
        @(posedge MCLK) SESS_RST <= 0;
        SEC_LEVEL_MAX <= 1;
        #1 chk(LOCKED, 1);
        unlock(1, MASTER_PW, 1, 3'h3);
        unlock(0, USER_PW, 0, 3'h3);
        @(posedge MCLK) FROZEN <= 1;
        refused;
        @(posedge MCLK) FROZEN <= 0;
        for (k = 2; k >= 0; k--) unlock(k[0], 0, 1, k[2:0]);
        refused;
        for (k = 0; k < 16; k++) seek(k[3:0], k[0]);
        @(posedge MCLK) RST_N <= 0;
        @(posedge MCLK) RST_N <= 1;
        #1 chk({LOCKED, TRIES_LEFT}, 4'hD);
        @(posedge MCLK) SEC_ENABLED <= 0;
        #1 chk(LOCKED, 0);
        report_and_stop;
    end
endmodule // test_sus_unlock_seek
